// [shared/sws_defs.vh]
// constants for the suspend and wake sequencer
`ifndef SWS_DEFS_VH
`define SWS_DEFS_VH
// register byte addresses
`define SWS_ADDR_CTRL      12'h000
`define SWS_ADDR_CLKCFG    12'h004
`define SWS_ADDR_WAKE_EN   12'h008
`define SWS_ADDR_STATUS    12'h00C
`define SWS_ADDR_IRQ_STAT  12'h010
`define SWS_ADDR_IRQ_MASK  12'h014
`define SWS_ADDR_WTMR      12'h018
// processor status and control register
`define SWS_PSC_IO_ADDR    8'hFF
`define SWS_PSC_ENTER_VAL  8'h09
`define SWS_PSC_RUN_BIT    0
`define SWS_PSC_IES_BIT    2
`define SWS_PSC_SUSP_BIT   3
`define SWS_PSC_RESET      8'h51
// clock configuration: bit 0 selects external oscillator on wake
`define SWS_CLK_EXT_BIT    0
`define SWS_CLK_DLY_BIT    1
// wake enable bits
`define SWS_WEN_GPIO       0
`define SWS_WEN_WTMR       1
`define SWS_WEN_SPI        2
`define SWS_WEN_DMINUS     3
// interrupt status bits
`define SWS_IRQ_SUSP       0
`define SWS_IRQ_WAKE       1
`define SWS_IRQ_RUNERR     2
// vectors
`define SWS_VEC_RESET      14'h0000
`define SWS_VEC_WAKE       14'h0016
// oscillator and internal delay in nanoseconds, external delays and wake timer period in clock cycles, clock rate in MHz
`define SWS_CLK_MHZ        250
`define SWS_T_OSC_INT_NS   2000
`define SWS_T_INT_DLY_NS   8000
`define SWS_EXT_DLY_SHORT  4096
`define SWS_EXT_DLY_LONG   32768
`define SWS_WTMR_RESET     16'h1000
`endif

// [hw/sws_delay_timer.v]
// down counter that times oscillator start and resume delay
`timescale 1ns/100ps
module sws_delay_timer #(
   parameter W = 20
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire         load,
   input  wire [W-1:0] load_val,
   output reg          expired
);
   reg [W-1:0] cnt_reg;
   reg         run_reg;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= {W{1'b0}};
         run_reg <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (load) begin
            cnt_reg <= load_val;
            run_reg <= 1'b1;
         end else if (run_reg) begin
            if (cnt_reg <= {{(W-1){1'b0}}, 1'b1}) begin
               run_reg <= 1'b0;
               expired <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule

// [hw/sws_sequencer.v]
// suspend and wake sequencer with apb register file
// Overview of operation
// - in suspend only gpio irq, data-minus receiver and wake timer stay powered
// - suspend stops both oscillators, free-running timer and watchdog
// - wake only on gpio irq, wake timer irq, spi slave irq or low data-minus
// - after wake, restart clocks; run only when oscillator stable and delay done
// - delay depends on internal or external clock and external resume delay
// - in suspend any enabled pending irq wakes when the run bit is set, ignoring global enable sense
// - a wake condition present at entry still enters suspend, then wakes
// - after wake the next instruction runs before pending interrupts
// - firmware enters suspend by writing 09h to io address FFh
// - clock config bit 0 picks wake clock; cleared means internal mode
// - internal oscillator runs within 2 us of the wake event
// - internal mode holds firmware for 8 us after the clock starts
// - optional wake timer keeps running in suspend and raises wake irq
// - wake irq uses vector 0x0016, reset starts at 0x0000
// - suspend is bit 3 and run bit 0 of status register at FFh
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "sws_defs.vh"
module sws_sequencer #(
   parameter EXT_DLY_SHORT = `SWS_EXT_DLY_SHORT,
   parameter EXT_DLY_LONG  = `SWS_EXT_DLY_LONG
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        core_io_wr,
   input  wire [7:0]  core_io_addr,
   input  wire [7:0]  core_io_data,
   input  wire        core_instr_done,
   input  wire        gpio_irq,
   input  wire        spi_slave_irq,
   input  wire        wtmr_irq_en,
   input  wire        usb_minus_ps2_data_pin,
   input  wire        irq_pending,
   output reg         core_halt,
   output reg         irq_hold,
   output reg         int_osc_en,
   output reg         ext_osc_en,
   output reg         timers_run,
   output reg         logic_pwr_en,
   output reg         wtmr_irq,
   output reg  [13:0] wake_vector,
   output reg         irq
);
   localparam ST_RUN   = 3'h0;
   localparam ST_SUSP  = 3'h1;
   localparam ST_OSC   = 3'h2;
   localparam ST_DLY   = 3'h3;
   localparam ST_FIRST = 3'h4;
   localparam integer OSC_CYC = (`SWS_T_OSC_INT_NS * `SWS_CLK_MHZ) / 1000;
   localparam integer INT_CYC = (`SWS_T_INT_DLY_NS * `SWS_CLK_MHZ + 999) / 1000;
   localparam integer OSC_LD  = (OSC_CYC > 1) ? OSC_CYC - 1 : 1;

   reg [2:0]  state_reg;
   reg [2:0]  state_next;
   reg [7:0]  psc_reg;
   reg [1:0]  clkcfg_reg;
   reg [3:0]  wake_en_reg;
   reg [2:0]  irq_stat_reg;
   reg [2:0]  irq_mask_reg;
   reg [15:0] wtmr_period_reg;
   reg [15:0] wtmr_cnt_reg;
   reg        susp_req_reg;
   reg        wake_ext_reg;
   reg        tmr_load;
   reg [19:0] tmr_val;
   wire       tmr_expired;
   wire       apb_wr;
   wire       apb_rd;
   wire       addr_ok;
   wire       wake_cond;
   wire       wake_evt;
   reg [2:0]  irq_set;
   reg [31:0] rd_mux;

   assign apb_wr = psel & penable & pwrite & pready;
   // read data is registered in setup so it stands together with pready
   assign apb_rd = psel & ~penable & ~pwrite;
   assign addr_ok = (paddr == `SWS_ADDR_CTRL) || (paddr == `SWS_ADDR_CLKCFG) ||
                    (paddr == `SWS_ADDR_WAKE_EN) || (paddr == `SWS_ADDR_STATUS) ||
                    (paddr == `SWS_ADDR_IRQ_STAT) || (paddr == `SWS_ADDR_IRQ_MASK) ||
                    (paddr == `SWS_ADDR_WTMR);

   // enabled sources only; global enable sense plays no part here
   assign wake_cond = (wake_en_reg[`SWS_WEN_GPIO] & gpio_irq) |
                      (wake_en_reg[`SWS_WEN_WTMR] & wtmr_irq) |
                      (wake_en_reg[`SWS_WEN_SPI] & spi_slave_irq) |
                      (wake_en_reg[`SWS_WEN_DMINUS] & ~usb_minus_ps2_data_pin);
   // run bit is required to leave suspend
   assign wake_evt = wake_cond & psc_reg[`SWS_PSC_RUN_BIT];

   sws_delay_timer #(
      .W(20)
   ) u_dly (
      .pclk     (pclk),
      .presetn  (presetn),
      .load     (tmr_load),
      .load_val (tmr_val),
      .expired  (tmr_expired)
   );

   always @* begin
      state_next = state_reg;
      tmr_load = 1'b0;
      tmr_val = 20'h00000;
      case (state_reg)
         ST_RUN: begin
            // always go through suspend, even with a wake already pending
            if (susp_req_reg) begin
               state_next = ST_SUSP;
            end
         end
         ST_SUSP: begin
            if (wake_evt) begin
               state_next = ST_OSC;
               tmr_load = 1'b1;
               tmr_val = OSC_LD[19:0];
            end
         end
         ST_OSC: begin
            if (tmr_expired) begin
               state_next = ST_DLY;
               tmr_load = 1'b1;
               // internal 8 us, external short or long setting
               if (!clkcfg_reg[`SWS_CLK_EXT_BIT]) begin
                  tmr_val = INT_CYC[19:0];
               end else if (clkcfg_reg[`SWS_CLK_DLY_BIT]) begin
                  tmr_val = EXT_DLY_LONG[19:0];
               end else begin
                  tmr_val = EXT_DLY_SHORT[19:0];
               end
            end
         end
         ST_DLY: begin
            if (tmr_expired) begin
               state_next = ST_FIRST;
            end
         end
         ST_FIRST: begin
            // one instruction before any interrupt is serviced
            if (core_instr_done) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   always @* begin
      irq_set = 3'h0;
      irq_set[`SWS_IRQ_SUSP] = (state_reg == ST_RUN) && susp_req_reg;
      irq_set[`SWS_IRQ_WAKE] = (state_reg == ST_DLY) && tmr_expired;
      irq_set[`SWS_IRQ_RUNERR] = (state_reg == ST_SUSP) && wake_cond &&
                                 !psc_reg[`SWS_PSC_RUN_BIT];
   end

   always @* begin
      rd_mux = 32'h00000000;
      case (paddr)
         `SWS_ADDR_CTRL:     rd_mux = {24'h000000, psc_reg[7:3], 1'b0, 1'b0, psc_reg[0]};
         `SWS_ADDR_CLKCFG:   rd_mux = {30'h00000000, clkcfg_reg};
         `SWS_ADDR_WAKE_EN:  rd_mux = {28'h0000000, wake_en_reg};
         `SWS_ADDR_STATUS:   rd_mux = {24'h000000, irq_pending, wtmr_irq, core_halt,
                                       2'b00, state_reg};
         `SWS_ADDR_IRQ_STAT: rd_mux = {29'h00000000, irq_stat_reg};
         `SWS_ADDR_IRQ_MASK: rd_mux = {29'h00000000, irq_mask_reg};
         `SWS_ADDR_WTMR:     rd_mux = {16'h0000, wtmr_period_reg};
         default:            rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_RUN;
         psc_reg <= `SWS_PSC_RESET;
         clkcfg_reg <= 2'b00;
         wake_en_reg <= 4'h0;
         irq_stat_reg <= 3'h0;
         irq_mask_reg <= 3'h0;
         wtmr_period_reg <= `SWS_WTMR_RESET;
         wtmr_cnt_reg <= 16'h0000;
         susp_req_reg <= 1'b0;
         wake_ext_reg <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         core_halt <= 1'b0;
         irq_hold <= 1'b0;
         int_osc_en <= 1'b1;
         ext_osc_en <= 1'b0;
         timers_run <= 1'b1;
         logic_pwr_en <= 1'b1;
         wtmr_irq <= 1'b0;
         wake_vector <= `SWS_VEC_RESET;
         irq <= 1'b0;
      end else begin
         state_reg <= state_next;
         // no wait state: answer in the cycle after setup
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         if (apb_rd) begin
            prdata <= rd_mux;
         end
         // the core write latches the request once the write is done
         susp_req_reg <= 1'b0;
         if (core_io_wr && core_io_addr == `SWS_PSC_IO_ADDR) begin
            psc_reg[`SWS_PSC_RUN_BIT] <= core_io_data[`SWS_PSC_RUN_BIT];
            psc_reg[`SWS_PSC_SUSP_BIT] <= core_io_data[`SWS_PSC_SUSP_BIT];
            susp_req_reg <= core_io_data[`SWS_PSC_SUSP_BIT];
         end else if (apb_wr && paddr == `SWS_ADDR_CTRL) begin
            psc_reg[`SWS_PSC_RUN_BIT] <= pwdata[`SWS_PSC_RUN_BIT];
            psc_reg[`SWS_PSC_SUSP_BIT] <= pwdata[`SWS_PSC_SUSP_BIT];
            susp_req_reg <= pwdata[`SWS_PSC_SUSP_BIT];
         end else if (state_reg == ST_DLY && tmr_expired) begin
            psc_reg[`SWS_PSC_SUSP_BIT] <= 1'b0;
         end
         if (apb_wr && paddr == `SWS_ADDR_CLKCFG) begin
            clkcfg_reg <= pwdata[1:0];
         end
         if (apb_wr && paddr == `SWS_ADDR_WAKE_EN) begin
            wake_en_reg <= pwdata[3:0];
         end
         if (apb_wr && paddr == `SWS_ADDR_IRQ_MASK) begin
            irq_mask_reg <= pwdata[2:0];
         end
         if (apb_wr && paddr == `SWS_ADDR_WTMR) begin
            wtmr_period_reg <= pwdata[15:0];
         end
         // set wins over write-one-to-clear
         if (apb_wr && paddr == `SWS_ADDR_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~pwdata[2:0]) | irq_set;
         end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
         end
         irq <= |((irq_stat_reg | irq_set) & irq_mask_reg);
         // wake timer stays alive in suspend when enabled
         wtmr_irq <= 1'b0;
         if (!wtmr_irq_en) begin
            wtmr_cnt_reg <= 16'h0000;
         end else if (wtmr_cnt_reg >= wtmr_period_reg) begin
            wtmr_cnt_reg <= 16'h0000;
            wtmr_irq <= 1'b1;
         end else begin
            wtmr_cnt_reg <= wtmr_cnt_reg + 16'h0001;
         end
         if (state_reg == ST_SUSP && wake_evt) begin
            wake_ext_reg <= clkcfg_reg[`SWS_CLK_EXT_BIT];
            wake_vector <= (wtmr_irq & wake_en_reg[`SWS_WEN_WTMR]) ?
                           `SWS_VEC_WAKE : `SWS_VEC_RESET;
         end
         // power and clock gating per state
         case (state_next)
            ST_SUSP: begin
               core_halt <= 1'b1;
               irq_hold <= 1'b1;
               int_osc_en <= 1'b0;
               ext_osc_en <= 1'b0;
               timers_run <= 1'b0;
               logic_pwr_en <= 1'b0;
            end
            ST_OSC, ST_DLY: begin
               core_halt <= 1'b1;
               irq_hold <= 1'b1;
               int_osc_en <= 1'b1;
               ext_osc_en <= (state_reg == ST_SUSP) ? clkcfg_reg[`SWS_CLK_EXT_BIT]
                                                    : wake_ext_reg;
               timers_run <= 1'b0;
               logic_pwr_en <= 1'b1;
            end
            ST_FIRST: begin
               core_halt <= 1'b0;
               irq_hold <= 1'b1;
               timers_run <= 1'b1;
               logic_pwr_en <= 1'b1;
            end
            default: begin
               core_halt <= 1'b0;
               irq_hold <= 1'b0;
               int_osc_en <= 1'b1;
               timers_run <= 1'b1;
               logic_pwr_en <= 1'b1;
            end
         endcase
      end
   end
endmodule

// [test/sws_checker.sv]
// port-level assertions for the suspend and wake sequencer
`timescale 1ns/100ps
module sws_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic core_halt,
   input wire logic irq_hold,
   input wire logic core_instr_done,
   input wire logic timers_run,
   input wire logic int_osc_en,
   input wire logic ext_osc_en,
   input wire logic logic_pwr_en,
   input wire logic wtmr_irq,
   input wire logic wtmr_irq_en
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   AST_APB_ANS: assert property (s_setup |=> s_access)
      else $error("no answer in access cycle");
   AST_RDY_ONE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_ERR_RDY: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_GATE_ALL: assert property ($fell(logic_pwr_en) |->
      core_halt && !timers_run && !int_osc_en && !ext_osc_en)
      else $error("suspend gating incomplete");
   AST_OSC_HOLD: assert property ($rose(int_osc_en) && core_halt |-> core_halt [*8])
      else $error("execution released too early");
   AST_HOLD_SET: assert property ($fell(core_halt) |-> irq_hold)
      else $error("interrupts not held at wake");
   AST_HOLD_REL: assert property (irq_hold && !core_halt && core_instr_done |=> !irq_hold)
      else $error("interrupt hold not released");
   AST_WTMR_ONE: assert property (wtmr_irq |=> !wtmr_irq)
      else $error("wake timer pulse too long");
   AST_WTMR_OFF: assert property (!wtmr_irq_en [*3] |-> !wtmr_irq)
      else $error("wake timer fired while disabled");
endmodule

// [test/sws_core_model.sv]
// processor core model: suspend entry write and first instruction after wake
`timescale 1ns/100ps
module sws_core_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       enter,
   input  wire logic       core_halt,
   output logic            core_io_wr,
   output logic [7:0]      core_io_addr,
   output logic [7:0]      core_io_data,
   output logic            core_instr_done
);
   logic halt_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_q <= 1'b0;
         core_io_wr <= 1'b0;
         core_io_addr <= 8'h00;
         core_io_data <= 8'h00;
         core_instr_done <= 1'b0;
      end else begin
         halt_q <= core_halt;
         core_io_wr <= enter;
         // idle bus toggles so a stale value is never mistaken for a write
         core_io_addr <= enter ? 8'hFF : ~core_io_addr;
         core_io_data <= enter ? 8'h09 : ~core_io_data;
         core_instr_done <= halt_q & ~core_halt;
      end
   end
endmodule

// [test/testbench.sv]
// self-checking bench for the suspend and wake sequencer
`timescale 1ns/100ps
`include "sws_defs.vh"
module testbench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, enter;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        core_io_wr, core_instr_done, gpio_irq, spi_slave_irq, wtmr_irq_en;
   logic        usb_minus_ps2_data_pin, core_halt, irq_hold, int_osc_en, ext_osc_en;
   logic        timers_run, logic_pwr_en, wtmr_irq, irq;
   logic [7:0]  core_io_addr, core_io_data;
   logic [13:0] wake_vector;
   int          failures, comparisons, n, k, t_osc;
   sws_sequencer #(.EXT_DLY_SHORT(8), .EXT_DLY_LONG(16)) i_dut (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_io_wr,
      .core_io_addr, .core_io_data, .core_instr_done, .gpio_irq, .spi_slave_irq,
      .wtmr_irq_en, .usb_minus_ps2_data_pin, .irq_pending(1'b0), .core_halt, .irq_hold,
      .int_osc_en, .ext_osc_en, .timers_run, .logic_pwr_en, .wtmr_irq, .wake_vector, .irq);
   sws_core_model i_core (.pclk, .presetn, .enter, .core_halt, .core_io_wr, .core_io_addr,
      .core_io_data, .core_instr_done);
   initial begin
      pclk = 0;
      forever #2 pclk = ~pclk;
   end
   task test_done;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task tmo;
      failures++;
      test_done;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) tmo;
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task rst;
      presetn <= 0;
      repeat (3) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      chk({core_halt, irq_hold, int_osc_en, ext_osc_en, timers_run, logic_pwr_en, irq,
         wtmr_irq, wake_vector}, {8'h2C, 14'h0000});
      apb(0, `SWS_ADDR_CTRL, 32'h0);
      chk(rd, 32'h51);
      apb(0, `SWS_ADDR_WTMR, 32'h0);
      chk(rd, 32'h1000);
      $display("reset test done");
   endtask
   // src: 0 gpio, 1 wake timer, 2 spi (pending before entry), 3 data-minus low, ext clock,
   // 4 data-minus low, ext clock with long delay
   task do_wake(input int src);
      apb(1, `SWS_ADDR_IRQ_STAT, 32'h7);
      apb(1, `SWS_ADDR_WAKE_EN, 32'h1 << (src > 3 ? 3 : src));
      apb(1, `SWS_ADDR_CLKCFG, {30'h0, src == 4, src > 2});
      wtmr_irq_en <= (src == 1);
      if (src == 2) spi_slave_irq <= 1;
      if (src % 2) apb(1, `SWS_ADDR_CTRL, 32'h9);
      else begin
         @(posedge pclk);
         enter <= 1;
         @(posedge pclk);
         enter <= 0;
      end
      repeat (5) @(posedge pclk);
      if (src != 2)
         chk({core_halt, int_osc_en, ext_osc_en, timers_run, logic_pwr_en}, 5'h10);
      gpio_irq <= (src == 0);
      usb_minus_ps2_data_pin <= (src < 3);
      t_osc = 0;
      n = 0;
      while (core_halt !== 1'b0 && n < 4000) begin
         @(posedge pclk);
         n++;
         if (t_osc == 0 && (int_osc_en | ext_osc_en)) t_osc = n;
      end
      if (n >= 4000) tmo;
      chk(t_osc <= 500, 1);
      // external: 2 us oscillator start plus the selected short or long delay
      chk(n - t_osc >= (src == 4 ? 516 : src == 3 ? 508 : 2000), 1);
      chk({ext_osc_en, irq_hold, wake_vector},
         {src > 2, 1'b1, src == 1 ? 14'h0016 : 14'h0000});
      repeat (3) @(posedge pclk);
      chk(irq_hold, 0);
      gpio_irq <= 0;
      spi_slave_irq <= 0;
      usb_minus_ps2_data_pin <= 1;
      wtmr_irq_en <= 0;
      apb(0, `SWS_ADDR_CTRL, 32'h0);
      chk(rd & 32'hF, 32'h1);
      apb(0, `SWS_ADDR_IRQ_STAT, 32'h0);
      chk(rd & 32'h3, 32'h3);
      $display("wake test %0d done", src);
   endtask
   initial begin
      failures = 0;
      comparisons = 0;
      {psel, penable, pwrite, paddr, pwdata, enter, gpio_irq, spi_slave_irq} = 0;
      wtmr_irq_en = 0;
      usb_minus_ps2_data_pin = 1;
      presetn = 0;
      rst;
      apb(1, `SWS_ADDR_WTMR, 32'h40);
      for (int s = 0; s < 5; s++) do_wake(s);
      apb(1, `SWS_ADDR_IRQ_MASK, 32'h2);
      repeat (2) @(posedge pclk);
      chk(irq, 1);
      apb(1, `SWS_ADDR_IRQ_STAT, 32'h2);
      repeat (2) @(posedge pclk);
      chk(irq, 0);
      apb(0, 12'h0FC, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      $display("register test done");
      // suspend without run must never resume
      apb(1, `SWS_ADDR_WAKE_EN, 32'h1);
      apb(1, `SWS_ADDR_CTRL, 32'h8);
      gpio_irq <= 1;
      repeat (3000) @(posedge pclk);
      chk(core_halt, 1);
      apb(0, `SWS_ADDR_IRQ_STAT, 32'h0);
      chk(rd & 32'h4, 32'h4);
      apb(0, `SWS_ADDR_STATUS, 32'h0);
      chk(rd, 32'h21);
      gpio_irq <= 0;
      $display("run bit test done");
      rst;
      test_done;
   end
endmodule
bind sws_sequencer sws_checker i_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .core_halt, .irq_hold, .core_instr_done, .timers_run, .int_osc_en, .ext_osc_en,
   .logic_pwr_en, .wtmr_irq, .wtmr_irq_en);
